/* rtl/dei_pkg.sv */
// constants and types for the drive enable block
//
// How it works
// RL1: either channel withdrawn cuts power, motor coasts
// RL2: stuck power path caught at next safety demand
// RL3: outside controller checks inputs against feedback contact
// RL4: hardware enable pin has no other function
// RL5: enable function off: input only stops, never starts
// RL6: start mode with level autostart starts on enable
// RL7: switch-on delay timer precedes power stage enable
// RL8: manual input forces terminal location and manual source
// RL9: installer must also assign a start input
// RL10: manual keeps control mode, flags fieldbus control bit
// RL11: no manual entry while powered or tool window
// RL12: manual ignores level autostart, needs start reset
// RL13: leaving manual stops motor control
// RL14: manual source selector decodes codes zero to eleven
// RL15: three standard outputs, brake relay use selectors
// RL16: second relay fixed to safe torque off status
// RL17: codes 0..3: off, error, brake, active
// RL18: code 4: device initialised after power-on
// RL19: code 5: enabled and no error
// RL20: codes 6..8: reference reached, homed, following error
// RL21: codes 9..12: standstill windows and quick stop
// RL22: start on input rising edge or bus start
// RL23: enable, torque-off, manual inputs double synchronised
package dei_pkg;

    // ====================
    // register map, byte addresses
    localparam logic [7:0] DEI_ADDR_CTRL = 8'h00;     // control bits
    localparam logic [7:0] DEI_ADDR_DELAY = 8'h04;    // switch-on delay in cycles
    localparam logic [7:0] DEI_ADDR_MAN = 8'h08;      // manual configuration
    localparam logic [7:0] DEI_ADDR_OUTSEL = 8'h0C;   // output function selectors
    localparam logic [7:0] DEI_ADDR_STATUS = 8'h10;   // read-only state
    localparam logic [7:0] DEI_ADDR_REFSRC = 8'h14;   // normal reference source

    // ====================
    // control register fields
    localparam int DEI_CTRL_ENFN = 0;        // enable function: 0 off, 1 start
    localparam int DEI_CTRL_AUTOLVL = 1;     // autostart level-triggered
    localparam int DEI_CTRL_DLYEN = 2;       // switch-on delay active
    localparam int DEI_CTRL_BUSSTART = 3;    // write 1: bus start bit
    localparam int DEI_CTRL_TOOLWIN = 4;     // tool manual window in use
    localparam int DEI_CTRL_FLTCLR = 5;      // write 1: clear stuck-path fault
    localparam logic [5:0] DEI_CTRL_RST = 6'h00;

    // manual register fields
    localparam int DEI_MAN_SRC_LSB = 0;      // manual source selector [3:0]
    localparam int DEI_MAN_IDX_LSB = 4;      // manual input index [6:4]
    localparam int DEI_MAN_EN = 7;           // manual function assigned
    localparam int DEI_START_IDX_LSB = 8;    // start input index [10:8]
    localparam int DEI_START_EN = 11;        // start function assigned
    localparam logic [11:0] DEI_MAN_RST = 12'h000;

    // output selectors, four bits each, relay default brake
    localparam int DEI_SEL_W = 4;
    localparam int DEI_NUM_OUT = 4;          // std 0..2, brake relay
    localparam logic [15:0] DEI_OUTSEL_RST = 16'h2000;
    localparam logic [15:0] DEI_DELAY_RST = 16'h0000;
    localparam logic [3:0] DEI_REFSRC_RST = 4'h0;

    // ====================
    // digital inputs
    localparam int DEI_NUM_DIN = 8;
    localparam int DEI_DIN_IDX_W = 3;

    // output function codes
    localparam logic [3:0] DEI_FN_OFF = 4'h0;
    localparam logic [3:0] DEI_FN_ERR = 4'h1;
    localparam logic [3:0] DEI_FN_BRAKE = 4'h2;
    localparam logic [3:0] DEI_FN_ACTIVE = 4'h3;
    localparam logic [3:0] DEI_FN_SRDY = 4'h4;
    localparam logic [3:0] DEI_FN_CRDY = 4'h5;
    localparam logic [3:0] DEI_FN_REF = 4'h6;
    localparam logic [3:0] DEI_FN_HOMED = 4'h7;
    localparam logic [3:0] DEI_FN_FLW = 4'h8;
    localparam logic [3:0] DEI_FN_CW = 4'h9;
    localparam logic [3:0] DEI_FN_CCW = 4'hA;
    localparam logic [3:0] DEI_FN_STILL = 4'hB;
    localparam logic [3:0] DEI_FN_QSTOP = 4'hC;

    // reference source codes
    localparam logic [3:0] DEI_SRC_NONE = 4'h0;
    localparam logic [3:0] DEI_SRC_ANALOG0 = 4'h1;
    localparam logic [3:0] DEI_SRC_ANALOG1 = 4'h2;
    localparam logic [3:0] DEI_SRC_TABLE = 4'h3;
    localparam logic [3:0] DEI_SRC_UNDEF = 4'h4;
    localparam logic [3:0] DEI_SRC_PLC = 4'h5;
    localparam logic [3:0] DEI_SRC_PARAM = 4'h6;
    localparam logic [3:0] DEI_SRC_CIA402 = 4'h7;
    localparam logic [3:0] DEI_SRC_SERCOS = 4'h8;
    localparam logic [3:0] DEI_SRC_PROFIBUS = 4'h9;
    localparam logic [3:0] DEI_SRC_ALTBUS = 4'hA;
    localparam logic [3:0] DEI_SRC_EXTSYNC = 4'hB;

    // drive states, one-hot
    typedef enum logic [2:0] {
        DEI_ST_IDLE = 3'b001,
        DEI_ST_DELAY = 3'b010,
        DEI_ST_RUN = 3'b100
    } dei_state_t;

    // status from the drive core
    typedef struct packed {
        logic init_done;        // initialisation after power-on finished
        logic error;            // collective error
        logic brake_ctrl;       // holding brake control
        logic ref_reached;      // reference reached
        logic homing_done;      // homing complete
        logic following_err;    // following error
        logic standstill_cw;    // standstill window, clockwise
        logic standstill_ccw;   // standstill window, anticlockwise
        logic standstill_act;   // standstill from actual value
        logic quick_stop;       // quick-stop state
        logic power_sense;      // readback of pulse amplifier supply
    } dei_drive_status_t;

    // commands to the drive core
    typedef struct packed {
        logic power_stage_en;   // pulse amplifier supply on
        logic control_active;   // motor control running
        logic manual_active;    // manual location active
        logic location_term;    // control location forced to terminal
        logic [3:0] ref_source; // selected reference source
    } dei_drive_cmd_t;

endpackage

/* rtl/dei_drive_enable.sv */
// drive enable, manual location and output selection
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps

module dei_drive_enable
    import dei_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // safety and enable pins
    input wire logic hw_enable_in,
    input wire logic safe_torque_off_in,
    input wire logic [DEI_NUM_DIN-1:0] digital_input_n,
    output logic sto_feedback_contact,
    // drive core
    input wire dei_drive_status_t drive_status,
    output dei_drive_cmd_t drive_cmd,
    output logic fieldbus_manual_bit,
    // outputs
    output logic std_output_0,
    output logic std_output_1,
    output logic std_output_2,
    output logic brake_relay_out,
    output logic safety_relay_out
);

    // ====================
    // helper functions

    // reference source decode
    function automatic logic [3:0] dei_src_decode(input logic [3:0] code);
        logic [3:0] res;
        res = DEI_SRC_NONE;
        unique case (code)
            DEI_SRC_ANALOG0, DEI_SRC_ANALOG1, DEI_SRC_TABLE, DEI_SRC_PLC,
            DEI_SRC_PARAM, DEI_SRC_CIA402, DEI_SRC_SERCOS, DEI_SRC_PROFIBUS,
            DEI_SRC_ALTBUS, DEI_SRC_EXTSYNC: res = code; // RL14
            default: res = DEI_SRC_NONE; // none and undefined codes
        endcase
        return res;
    endfunction

    // output function selection
    function automatic logic dei_out_fn(input logic [3:0] sel, input dei_drive_status_t st,
                                        input logic active, input logic rdy);
        logic res;
        res = 1'b0;
        unique case (sel)
            DEI_FN_OFF: res = 1'b0; // RL17
            DEI_FN_ERR: res = st.error; // RL17
            DEI_FN_BRAKE: res = st.brake_ctrl; // RL17
            DEI_FN_ACTIVE: res = active; // RL17
            DEI_FN_SRDY: res = st.init_done; // RL18
            DEI_FN_CRDY: res = rdy; // RL19
            DEI_FN_REF: res = st.ref_reached; // RL20
            DEI_FN_HOMED: res = st.homing_done; // RL20
            DEI_FN_FLW: res = st.following_err; // RL20
            DEI_FN_CW: res = st.standstill_cw; // RL21
            DEI_FN_CCW: res = st.standstill_ccw; // RL21
            DEI_FN_STILL: res = st.standstill_act; // RL21
            DEI_FN_QSTOP: res = st.quick_stop; // RL21
            default: res = 1'b0; // unused codes
        endcase
        return res;
    endfunction

    // ====================
    // reset release

    logic [1:0] rst_sync_r; // reset release chain
    logic rst_n; // synchronised reset

    // release reset through two flops
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ====================
    // input synchronisers

    localparam int SYNC_W = DEI_NUM_DIN + 2;
    logic [SYNC_W-1:0] sync1_r; // first stage, read only by second
    logic [SYNC_W-1:0] sync2_r; // second stage
    logic en_s; // hardware enable, synchronised
    logic sto_s; // torque-off input released, synchronised
    logic [DEI_NUM_DIN-1:0] din_s; // digital inputs, active high

    // two flops on the enable, torque-off and digital input pins before use
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {hw_enable_in, safe_torque_off_in, ~digital_input_n}; // RL23
            sync2_r <= sync1_r; // RL23
        end
    end
    assign en_s = sync2_r[SYNC_W-1];
    assign sto_s = sync2_r[SYNC_W-2];
    assign din_s = sync2_r[DEI_NUM_DIN-1:0];

    // ====================
    // registers

    logic [5:0] ctrl_r; // control bits
    logic [15:0] delay_r; // switch-on delay in cycles
    logic [11:0] man_r; // manual configuration
    logic [15:0] outsel_r; // output selectors
    logic [3:0] refsrc_r; // normal reference source
    logic bus_start_r; // one-cycle bus start pulse
    logic fault_clr_r; // one-cycle fault clear pulse
    logic [31:0] prdata_r; // read data
    logic [31:0] status_word; // status register view
    logic wr_en; // write taken this edge
    logic mapped; // address decodes

    dei_state_t state_r; // drive state
    logic [15:0] dly_cnt_r; // delay counter
    logic man_r_act; // manual active flop
    logic start_armed_r; // start input seen low since manual entry
    logic start_prev_r; // start input last cycle
    logic sto_fault_r; // stuck power path detected
    logic demand_prev_r; // safety demand last cycle

    assign wr_en = psel && penable && pwrite;

    // address decode
    always_comb begin
        unique case (paddr)
            DEI_ADDR_CTRL, DEI_ADDR_DELAY, DEI_ADDR_MAN, DEI_ADDR_OUTSEL,
            DEI_ADDR_STATUS, DEI_ADDR_REFSRC: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // zero-wait answer
    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_r;

    // software-written configuration
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= DEI_CTRL_RST;
            delay_r <= DEI_DELAY_RST;
            man_r <= DEI_MAN_RST;
            outsel_r <= DEI_OUTSEL_RST; // RL15
            refsrc_r <= DEI_REFSRC_RST;
        end else if (wr_en) begin
            unique case (paddr)
                DEI_ADDR_CTRL: ctrl_r <= pwdata[5:0];
                DEI_ADDR_DELAY: delay_r <= pwdata[15:0];
                DEI_ADDR_MAN: man_r <= pwdata[11:0];
                DEI_ADDR_OUTSEL: outsel_r <= pwdata[15:0]; // RL15
                DEI_ADDR_REFSRC: refsrc_r <= pwdata[3:0];
                default: ; // read-only or unmapped
            endcase
        end
    end

    // self-clearing command pulses
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_start_r <= 1'b0;
            fault_clr_r <= 1'b0;
        end else begin
            bus_start_r <= wr_en && paddr == DEI_ADDR_CTRL && pwdata[DEI_CTRL_BUSSTART];
            fault_clr_r <= wr_en && paddr == DEI_ADDR_CTRL && pwdata[DEI_CTRL_FLTCLR];
        end
    end

    // status view
    assign status_word = {20'h00000, drive_cmd.ref_source, sto_fault_r, start_armed_r,
                          man_r_act, state_r == DEI_ST_RUN, state_r == DEI_ST_DELAY,
                          drive_cmd.power_stage_en, sto_s, en_s};

    // read data captured in the setup cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                DEI_ADDR_CTRL: prdata_r <= {26'h0, 1'b0, ctrl_r[DEI_CTRL_TOOLWIN],
                                            1'b0, ctrl_r[2:0]};
                DEI_ADDR_DELAY: prdata_r <= {16'h0000, delay_r};
                DEI_ADDR_MAN: prdata_r <= {20'h00000, man_r};
                DEI_ADDR_OUTSEL: prdata_r <= {16'h0000, outsel_r};
                DEI_ADDR_STATUS: prdata_r <= status_word;
                DEI_ADDR_REFSRC: prdata_r <= {28'h0000000, refsrc_r};
                default: prdata_r <= 32'h00000000;
            endcase
        end
    end

    // ====================
    // input function routing

    logic man_in; // manual input asserted
    logic start_in; // start input asserted
    logic start_edge; // start input rising edge
    logic both_ch; // both safety channels present
    logic man_enter; // manual entry allowed now
    logic level_start; // level autostart condition
    logic edge_start; // edge or bus start condition
    logic start_req; // any accepted start

    assign man_in = man_r[DEI_MAN_EN]
                    && din_s[man_r[DEI_MAN_IDX_LSB +: DEI_DIN_IDX_W]];
    assign start_in = man_r[DEI_START_EN]
                      && din_s[man_r[DEI_START_IDX_LSB +: DEI_DIN_IDX_W]];
    assign start_edge = start_in && !start_prev_r; // RL22
    assign both_ch = en_s && sto_s; // RL1

    // manual blocked while powered or in tool window
    assign man_enter = man_in && !man_r_act && state_r == DEI_ST_IDLE
                       && !ctrl_r[DEI_CTRL_TOOLWIN]; // RL11

    // level autostart
    assign level_start = ctrl_r[DEI_CTRL_ENFN] && ctrl_r[DEI_CTRL_AUTOLVL]
                         && !man_r_act; // RL6 RL12 RL5

    // edge or bus start, manual needs start reset first
    assign edge_start = (start_edge && (!man_r_act || start_armed_r))
                        || (bus_start_r && !man_r_act); // RL22 RL12

    assign start_req = both_ch && drive_status.init_done && !drive_status.error
                       && !sto_fault_r && (level_start || edge_start);

    // start edge history
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_prev_r <= 1'b0;
        end else begin
            start_prev_r <= start_in;
        end
    end

    // ====================
    // manual location

    // enter on input when allowed, leave when input drops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            man_r_act <= 1'b0;
        end else if (man_enter) begin
            man_r_act <= 1'b1; // RL8
        end else if (!man_in) begin
            man_r_act <= 1'b0;
        end
    end

    // start must be seen low after manual entry
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_armed_r <= 1'b0;
        end else if (man_enter) begin
            start_armed_r <= 1'b0; // RL12
        end else if (!start_in) begin
            start_armed_r <= 1'b1; // RL12
        end
    end

    // ====================
    // drive state machine

    // idle, switch-on delay, running
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= DEI_ST_IDLE;
            dly_cnt_r <= 16'h0000;
        end else if (!both_ch || sto_fault_r) begin
            state_r <= DEI_ST_IDLE; // RL1 RL5 RL2
            dly_cnt_r <= 16'h0000;
        end else if (man_r_act && !man_in) begin
            state_r <= DEI_ST_IDLE; // RL13
            dly_cnt_r <= 16'h0000;
        end else begin
            unique case (state_r)
                DEI_ST_IDLE: begin
                    if (start_req && ctrl_r[DEI_CTRL_DLYEN]) begin
                        state_r <= DEI_ST_DELAY; // RL7
                        dly_cnt_r <= delay_r;
                    end else if (start_req) begin
                        state_r <= DEI_ST_RUN; // RL6 RL22
                    end
                end
                DEI_ST_DELAY: begin
                    if (dly_cnt_r == 16'h0000) begin
                        state_r <= DEI_ST_RUN; // RL7
                    end else begin
                        dly_cnt_r <= dly_cnt_r - 16'h0001; // RL7
                    end
                end
                DEI_ST_RUN: begin
                    state_r <= DEI_ST_RUN;
                end
            endcase
        end
    end

    // ====================
    // stuck power path detection

    logic demand; // safety function requested

    assign demand = !both_ch;

    // sense still on one cycle into a demand, or on while not running (idle or delay)
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            demand_prev_r <= 1'b0;
            sto_fault_r <= 1'b0;
        end else begin
            demand_prev_r <= demand;
            if ((demand_prev_r || state_r != DEI_ST_RUN) && !drive_cmd.power_stage_en
                && drive_status.power_sense) begin
                sto_fault_r <= 1'b1; // RL2
            end else if (fault_clr_r) begin
                sto_fault_r <= 1'b0;
            end
        end
    end

    // ====================
    // drive commands and outputs

    logic [DEI_NUM_OUT-1:0] out_r; // selected output levels
    logic rdy_on; // ready to switch on
    logic active; // power stage and control active

    assign rdy_on = en_s && !drive_status.error; // RL19
    assign active = state_r == DEI_ST_RUN;

    // drive command word
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_cmd <= '0;
            fieldbus_manual_bit <= 1'b0;
        end else begin
            drive_cmd.power_stage_en <= active && both_ch && !sto_fault_r; // RL1 RL4
            drive_cmd.control_active <= active && both_ch; // RL1
            drive_cmd.manual_active <= man_r_act; // RL10
            drive_cmd.location_term <= man_r_act; // RL8
            drive_cmd.ref_source <= man_r_act ? dei_src_decode(man_r[3:0]) // RL8 RL14
                                              : dei_src_decode(refsrc_r);
            fieldbus_manual_bit <= man_r_act; // RL10
        end
    end

    // one selector per output
    genvar gi;
    generate
        for (gi = 0; gi < DEI_NUM_OUT; gi++) begin : g_out
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    out_r[gi] <= 1'b0;
                end else begin
                    out_r[gi] <= dei_out_fn(outsel_r[gi*DEI_SEL_W +: DEI_SEL_W],
                                            drive_status, active, rdy_on); // RL15
                end
            end
        end
    endgenerate

    // torque-off status relay and feedback contact
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            safety_relay_out <= 1'b0;
            sto_feedback_contact <= 1'b0;
        end else begin
            safety_relay_out <= !sto_s; // RL16
            sto_feedback_contact <= !sto_s && !drive_status.power_sense; // RL3
        end
    end

    assign std_output_0 = out_r[0];
    assign std_output_1 = out_r[1];
    assign std_output_2 = out_r[2];
    assign brake_relay_out = out_r[3];

endmodule

/* dv/dei_drive_enable_properties.sv */
// assertion checker for the drive enable block
`timescale 1ns/1ps
module dei_drive_enable_properties
    import dei_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic hw_enable_in,
    input wire logic safe_torque_off_in,
    input wire dei_drive_cmd_t drive_cmd,
    input wire logic fieldbus_manual_bit,
    input wire logic safety_relay_out
);
    // ====================
    // channel cut-off, fixed relay, manual location
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    a_sto_cut: assert property (!safe_torque_off_in [*8] |-> !drive_cmd.power_stage_en)
        else $error("stage on in torque-off");
    a_enable_cut: assert property (!hw_enable_in [*8] |-> !drive_cmd.power_stage_en)
        else $error("stage on without enable");
    a_relay_fixed: assert property (!safe_torque_off_in [*8] |-> safety_relay_out)
        else $error("relay not at torque-off");
    a_manual_bit: assert property (
        $rose(drive_cmd.manual_active) |-> ##[0:1] fieldbus_manual_bit)
        else $error("manual bit missing");
    a_manual_term: assert property (
        drive_cmd.manual_active [*2] |-> drive_cmd.location_term)
        else $error("manual not terminal");
    a_no_manual_run: assert property (
        $rose(drive_cmd.manual_active) |-> !drive_cmd.power_stage_en)
        else $error("manual entered powered");
    a_manual_stop: assert property (
        $fell(drive_cmd.manual_active) |-> ##[0:2] !drive_cmd.control_active)
        else $error("control after manual");
    a_src_legal: assert property (
        drive_cmd.ref_source != 4'h4 && drive_cmd.ref_source < 4'hC)
        else $error("bad reference source");
endmodule

bind dei_drive_enable dei_drive_enable_properties chk_u (.core_clk, .reset_n, .hw_enable_in,
    .safe_torque_off_in, .drive_cmd, .fieldbus_manual_bit, .safety_relay_out);

/* dv/dei_plc_model.sv */
// machine safety controller: drives both enable channels, checks the feedback contact
`timescale 1ns/1ps
module dei_plc_model (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic en_cmd,
    input wire logic sto_cmd,
    input wire logic sto_feedback_contact,
    output logic hw_enable_in = 1'b0,
    output logic safe_torque_off_in = 1'b0,
    output logic sys_err = 1'b0
);
    logic [3:0] mis_r = 4'h0; // cycles of implausible feedback
    // feedback equal to the channel input for 15 cycles trips
    always @(posedge core_clk) begin
        mis_r <= (reset_n && sto_feedback_contact == safe_torque_off_in)
            ? mis_r + 4'h1 : 4'h0;
        if (mis_r == 4'hF) sys_err <= 1'b1;
        hw_enable_in <= en_cmd && !sys_err;
        safe_torque_off_in <= sto_cmd && !sys_err;
    end
endmodule

/* dv/drive_enable_io_select_tb_top.sv */
// self-checking bench for the drive enable block
`timescale 1ns/1ps
module drive_enable_io_select_tb_top
    import dei_pkg::*;
;
    logic core_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, din = 8'hFF;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, hw_en, sto, fb, en_cmd = 1'b0, sto_cmd = 1'b0, sys_err;
    logic fbm, o0, o1, o2, brk, rly;
    logic [10:0] st = 11'h400; // drive status, init done only
    dei_drive_cmd_t cmd;
    int bad_count = 0, n_compared = 0;
    int bit_of [13] = '{0, 9, 8, 0, 10, 0, 7, 6, 5, 4, 3, 2, 1}; // status bit per output code
    initial forever #5 core_clk = ~core_clk;
    dei_drive_enable dut_u (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .hw_enable_in(hw_en), .safe_torque_off_in(sto),
        .digital_input_n(din), .sto_feedback_contact(fb),
        .drive_status({st[10:1], cmd.power_stage_en | st[0]}), .drive_cmd(cmd),
        .fieldbus_manual_bit(fbm), .std_output_0(o0), .std_output_1(o1), .std_output_2(o2),
        .brake_relay_out(brk), .safety_relay_out(rly));
    dei_plc_model plc_u (.core_clk, .reset_n, .en_cmd, .sto_cmd, .sto_feedback_contact(fb),
        .hw_enable_in(hw_en), .safe_torque_off_in(sto), .sys_err);
    // ====================
    // compare, bus access and wait helpers
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, e);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1 && ++n < 50);
        if (!wr) chk("prdata", e, prdata);
        chk("pslverr", {31'h0, a > 8'h14}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_pse(input logic v, input int lo, hi);
        int n;
        n = 0;
        while (cmd.power_stage_en !== v && n < 60) begin
            @(posedge core_clk);
            n++;
        end
        chk("stage delay", 1, {31'h0, n >= lo && n <= hi});
    endtask
    task automatic tally_and_finish();
        if (bad_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ====================
    // main sequence
    initial begin
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        apb(0, DEI_ADDR_OUTSEL, 0, 32'h2000);
        apb(0, 8'h18, 0, 0); // unmapped place
        apb(1, DEI_ADDR_OUTSEL, 32'h2053, 0);
        for (int k = 0; k < 16; k++) begin
            apb(1, DEI_ADDR_REFSRC, k, 0);
            repeat (3) @(posedge core_clk);
            chk("ref source", (k == 4 || k > 11) ? 0 : k, cmd.ref_source);
        end
        apb(1, DEI_ADDR_CTRL, 32'h2, 0);
        en_cmd <= 1'b1;
        sto_cmd <= 1'b1;
        repeat (12) @(posedge core_clk);
        chk("start with fn off", 0, cmd.power_stage_en);
        chk("ready output", 1, o1);
        chk("off output", 0, o2);
        apb(1, DEI_ADDR_CTRL, 32'h3, 0);
        wait_pse(1, 0, 10);
        repeat (3) @(posedge core_clk);
        chk("active output", 1, o0);
        en_cmd <= 1'b0;
        wait_pse(0, 1, 8);
        en_cmd <= 1'b1;
        wait_pse(1, 1, 10);
        sto_cmd <= 1'b0;
        wait_pse(0, 1, 8);
        repeat (6) @(posedge core_clk);
        chk("safety relay", 1, rly);
        chk("feedback", 1, fb);
        apb(1, DEI_ADDR_DELAY, 5, 0);
        apb(1, DEI_ADDR_CTRL, 32'h7, 0);
        sto_cmd <= 1'b1;
        wait_pse(1, 9, 16);
        en_cmd <= 1'b0;
        apb(1, DEI_ADDR_CTRL, 32'h3, 0);
        apb(1, DEI_ADDR_MAN, 32'h981, 0);
        din[0] <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk("manual source", 1, cmd.ref_source);
        chk("manual flag", 1, fbm);
        en_cmd <= 1'b1;
        repeat (12) @(posedge core_clk);
        chk("manual level", 0, cmd.power_stage_en);
        din[1] <= 1'b0;
        wait_pse(1, 1, 10);
        apb(1, DEI_ADDR_CTRL, 32'h1, 0);
        din[0] <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk("manual end", 0, cmd.control_active);
        apb(1, DEI_ADDR_CTRL, 32'h3, 0);
        wait_pse(1, 0, 10);
        din[0] <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk("manual refused", 0, fbm);
        din <= 8'hFF;
        en_cmd <= 1'b0;
        for (int c = 1; c < 13; c++) begin
            if (bit_of[c] == 0) continue;
            apb(1, DEI_ADDR_OUTSEL, {c[3:0], 8'h00, c[3:0]}, 0);
            st <= 11'h1 << bit_of[c];
            repeat (4) @(posedge core_clk);
            chk("output on", 32'h3, {o0, brk});
            st <= 11'h000;
            repeat (4) @(posedge core_clk);
            chk("output off", 32'h0, {o0, brk});
        end
        st <= 11'h401;
        en_cmd <= 1'b1;
        repeat (12) @(posedge core_clk);
        apb(0, DEI_ADDR_STATUS, 0, 32'hC3);
        chk("plausibility", 0, sys_err);
        tally_and_finish();
    end
    initial begin
        #200000;
        bad_count++;
        tally_and_finish();
    end
endmodule
